// ===== common/pmm_defs.vh
// constants for the phy/mac management handshake block
// assumes inclusion by bare name from design files
`ifndef PMM_DEFS_VH
`define PMM_DEFS_VH

// -----------------------------------------------------------------------------
// register word addresses (word index as driven on avs_address)
// -----------------------------------------------------------------------------
`define PMM_ADDR_W 4
`define PMM_OFS_CMD 4'h0
`define PMM_OFS_STATUS 4'h1
`define PMM_OFS_MIB 4'h2
`define PMM_OFS_SCAN 4'h3
`define PMM_OFS_TIMER 4'h4
`define PMM_OFS_REPORT 4'h5
`define PMM_OFS_REPORT2 4'h6

// -----------------------------------------------------------------------------
// command register bits (write one to issue request)
// -----------------------------------------------------------------------------
`define PMM_CMD_PHY_RST 0
`define PMM_CMD_RT_EN 1
`define PMM_CMD_RT_DIS 2
`define PMM_CMD_MAC_RST 3
`define PMM_CMD_SCAN 4

// -----------------------------------------------------------------------------
// status register bits (sticky confirms, write one to clear; PMM_ST_RT_ON is a live copy)
// -----------------------------------------------------------------------------
`define PMM_ST_PHY_CONF 0
`define PMM_ST_PHY_OUT 1
`define PMM_ST_RT_EN_CONF 2
`define PMM_ST_RT_DIS_CONF 3
`define PMM_ST_MAC_CONF 4
`define PMM_ST_MAC_OUT 5
`define PMM_ST_SCAN_CONF 6
`define PMM_ST_SCAN_OUT 7
`define PMM_ST_HDR 8
`define PMM_ST_RT_ON 9
`define PMM_ST_W 10

// -----------------------------------------------------------------------------
// encodings and reset values
// -----------------------------------------------------------------------------
`define PMM_OUT_SUCCESS 1'b0
`define PMM_OUT_FAILED 1'b1
`define PMM_ADDR_PRIVATE 1'b0
`define PMM_ADDR_GENERATED 1'b1
`define PMM_SCAN_DISABLED 2'h0
`define PMM_SCAN_ONLY 2'h1
`define PMM_SCAN_EXCEPT_BP 2'h2
`define PMM_SCAN_WHEN_IDLE 2'h3
`define PMM_SEC_MAX 2'h2
`define PMM_RST_CYCLES 4'h8

`endif

// ===== tb/pmm_far_end.sv
// datapath far end: ranging counter and header source
// assumes hdr_go is a one-cycle strobe from the bench
`timescale 1ns/1ps
module pmm_far_end (
  input wire logic clk,
  input wire logic hdr_go,
  output logic [31:0] range_timer_count,
  output logic hdr_rx,
  output logic [15:0] hdr_beacon_start_offset,
  output logic [7:0] hdr_link_quality,
  output logic [7:0] hdr_signal_strength
);
  initial range_timer_count = 32'hFFFFF000;
  initial hdr_rx = 1'b0;
  always @(posedge clk) begin
    range_timer_count <= range_timer_count + 32'h1;
    hdr_rx <= hdr_go;
  end
  // fields scramble outside the header pulse
  assign hdr_beacon_start_offset = hdr_rx ? 16'hFFFF : range_timer_count[15:0];
  assign hdr_link_quality = hdr_rx ? 8'h00 : ~range_timer_count[7:0];
  assign hdr_signal_strength = hdr_rx ? 8'hFF : range_timer_count[7:0];
endmodule

// ===== tb/pmm_mgmt_ctrl_props.sv
// assertions on the management block ports
// assumes bind onto pmm_mgmt_ctrl, one clock
`timescale 1ns/1ps
module pmm_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic phy_tx_clear,
  input wire logic phy_rx_clear,
  input wire logic phy_sense_clear,
  input wire logic mac_buf_flush,
  input wire logic mac_txrx_enable,
  input wire logic scan_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_ANSWER: assert property (
    (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest) else $error("no ack");
  AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("ack too long");
  AST_RST_DEF: assert property ($fell(srst) |-> avs_waitrequest && !scan_active
    && !mac_txrx_enable && !mac_buf_flush) else $error("bad reset values");
  AST_PHY_ALL: assert property ($rose(phy_tx_clear) |-> phy_rx_clear && phy_sense_clear)
    else $error("phy clears split");
  AST_PHY_LEN: assert property ($rose(phy_tx_clear) |-> phy_tx_clear[*8] ##1 !phy_tx_clear)
    else $error("phy clear length");
  AST_FLUSH_OFF: assert property (mac_buf_flush |=> !mac_txrx_enable)
    else $error("traffic during flush");
  AST_FLUSH_END: assert property ($fell(mac_buf_flush) |-> !mac_txrx_enable && !scan_active)
    else $error("active after mac reset");
  AST_TXRX_CAUSE: assert property ($rose(mac_txrx_enable) |-> $past(avs_write))
    else $error("traffic without request");
  cover property ($rose(phy_tx_clear));
  cover property ($fell(mac_buf_flush));
  cover property ($rose(scan_active));
endmodule

// ===== tb/pmm_mgmt_ctrl_tb_top.sv
// self-checking bench for the management block
// assumes pmm_far_end as datapath partner, bench as bus master
`timescale 1ns/1ps
module pmm_mgmt_ctrl_tb_top;
  logic clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, hdr_go = 1'b0;
  logic beacon_period = 1'b0, link_scheduled = 1'b0, avs_waitrequest, hdr_rx;
  logic phy_tx_clear, phy_rx_clear, phy_sense_clear, mac_buf_flush, mac_txrx_enable;
  logic scan_active;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, range_timer_count, rd, t0;
  logic [15:0] hdr_beacon_start_offset;
  logic [7:0] hdr_link_quality, hdr_signal_strength;
  logic [4:0] channel_sel;
  int error_cnt = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  pmm_mgmt_ctrl pmm_mgmt_ctrl_i (.clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .range_timer_count(range_timer_count), .beacon_period(beacon_period),
    .link_scheduled(link_scheduled), .hdr_rx(hdr_rx),
    .hdr_beacon_start_offset(hdr_beacon_start_offset), .hdr_link_quality(hdr_link_quality),
    .hdr_signal_strength(hdr_signal_strength), .phy_tx_clear(phy_tx_clear),
    .phy_rx_clear(phy_rx_clear), .phy_sense_clear(phy_sense_clear),
    .mac_buf_flush(mac_buf_flush), .mac_txrx_enable(mac_txrx_enable),
    .scan_active(scan_active), .channel_sel(channel_sel));
  pmm_far_end pmm_far_end_i (.clk(clk), .hdr_go(hdr_go), .range_timer_count(range_timer_count),
    .hdr_rx(hdr_rx), .hdr_beacon_start_offset(hdr_beacon_start_offset),
    .hdr_link_quality(hdr_link_quality), .hdr_signal_strength(hdr_signal_strength));
  // ----
  // bus and compare helpers
  // ----
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) chk(32'h1, 32'h0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task rc(input logic [3:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task hdr;
    hdr_go <= 1'b1;
    @(posedge clk);
    hdr_go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task t_idle;
    rc(4'h1, 32'h0);
    rc(4'h3, 32'h0);
    rc(4'h9, 32'h0);
    av(1'b1, 4'h2, 32'h5);
    rc(4'h2, 32'h5);
    av(1'b1, 4'h2, 32'h6);
    rc(4'h2, 32'h4);
    $display("idle and store done");
  endtask
  task t_phy;
    av(1'b1, 4'h0, 32'h1);
    @(posedge clk);
    #1 chk({phy_tx_clear, phy_rx_clear, phy_sense_clear}, 32'h7);
    repeat (12) @(posedge clk);
    #1 chk({phy_tx_clear, phy_rx_clear, phy_sense_clear}, 32'h0);
    @(posedge clk);
    rc(4'h1, 32'h1);
    av(1'b1, 4'h1, 32'h3);
    $display("phy reset done");
  endtask
  task t_timer;
    av(1'b1, 4'h0, 32'h2);
    rc(4'h1, 32'h204);
    av(1'b0, 4'h4, 32'h0);
    t0 = rd;
    av(1'b0, 4'h4, 32'h0);
    chk(rd - t0, 32'h3);
    chk(rd[31:16], 32'hFFFF);
    av(1'b1, 4'h0, 32'h4);
    rc(4'h1, 32'hC);
    av(1'b0, 4'h4, 32'h0);
    t0 = rd;
    rc(4'h4, t0);
    av(1'b1, 4'h1, 32'hC);
    $display("timer done");
  endtask
  task t_scan;
    for (int m = 1; m < 4; m++) begin
      av(1'b1, 4'h0, 32'h10 | (m << 8) | ((m + 16) << 16));
      av(1'b0, 4'h3, 32'h0);
      chk(channel_sel, m + 16);
      chk(rd & 32'h3, m);
      rc(4'h1, 32'h40);
      av(1'b1, 4'h1, 32'hC0);
      beacon_period <= 1'b1;
      link_scheduled <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(scan_active, m == 1);
      if (m == 1) chk(mac_txrx_enable, 32'h0);
      @(posedge clk);
      beacon_period <= 1'b0;
      link_scheduled <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk(scan_active, 32'h1);
      @(posedge clk);
    end
    hdr();
    rc(4'h1, 32'h100);
    rc(4'h5, 32'hFFFF);
    rc(4'h6, 32'hFF00);
    av(1'b1, 4'h1, 32'h100);
    $display("scan done");
  endtask
  task t_mac;
    av(1'b1, 4'h0, 32'h8);
    @(posedge clk);
    #1 chk(mac_buf_flush, 32'h1);
    repeat (12) @(posedge clk);
    #1 chk({mac_buf_flush, mac_txrx_enable, scan_active}, 32'h0);
    @(posedge clk);
    rc(4'h1, 32'h10);
    av(1'b0, 4'h3, 32'h0);
    chk(rd & 32'h3, 32'h0);
    rc(4'h2, 32'h0);
    av(1'b1, 4'h1, 32'h10);
    hdr();
    rc(4'h1, 32'h0);
    $display("mac reset done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_idle();
    t_phy();
    t_timer();
    t_scan();
    t_mac();
    conclude();
  end
  initial begin
    #300000;
    error_cnt++;
    conclude();
  end
endmodule
bind pmm_mgmt_ctrl pmm_chk pmm_chk_i (.clk(clk), .srst(srst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .phy_tx_clear(phy_tx_clear),
  .phy_rx_clear(phy_rx_clear), .phy_sense_clear(phy_sense_clear),
  .mac_buf_flush(mac_buf_flush), .mac_txrx_enable(mac_txrx_enable), .scan_active(scan_active));

// ===== verilog/pmm_mgmt_ctrl.v
// management request/confirm block for a wireless phy/mac pair
// assumes an avalon-mm master on clk; datapath strobes synchronous to clk
//
// Overview of operation
// - phy reset clears tx, rx, sensing, ranging timer
// - phy reset ends with one outcome confirm
// - phy outcome is success or failed
// - enable request switches ranging timer on
// - while enabled capture timer, then confirm
// - timer attribute is 32-bit unsigned
// - disable request stops timer, then confirms
// - mac reset restores state machines, store defaults
// - mac reset discards all buffered frames
// - after mac reset no tx/rx until request
// - mac reset ends with success/failure confirm
// - store holds address kind and security mode
// - scan-only blocks all other tx/rx
// - except-beacon mode scans outside beacon period
// - idle mode scans only when unscheduled
// - scan state disabled at power-up, mac reset
// - report holds offset, link quality, strength
// - scan confirm once state entered or failed
// - header report only while scan not disabled
`timescale 1ns/1ps
`include "pmm_defs.vh"

module pmm_mgmt_ctrl #(
  parameter CHAN_W = 5,
  parameter RST_CYCLES = `PMM_RST_CYCLES
) (
  input wire clk,
  input wire srst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [31:0] range_timer_count,
  input wire beacon_period,
  input wire link_scheduled,
  input wire hdr_rx,
  input wire [15:0] hdr_beacon_start_offset,
  input wire [7:0] hdr_link_quality,
  input wire [7:0] hdr_signal_strength,
  output reg phy_tx_clear,
  output reg phy_rx_clear,
  output reg phy_sense_clear,
  output reg mac_buf_flush,
  output reg mac_txrx_enable,
  output reg scan_active,
  output reg [CHAN_W-1:0] channel_sel
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_PHY = 2'd1;
  localparam ST_MAC = 2'd2;
  localparam [3:0] CNT_LOAD = RST_CYCLES[3:0];

  reg [1:0] state_q;
  reg [3:0] cnt_q;
  wire [`PMM_ST_W-1:0] status_q;
  reg range_timer_on_q;
  reg [31:0] range_timer_value_q;
  reg device_addr_kind_q;
  reg [1:0] security_mode_sel_q;
  reg [1:0] scan_state_q;
  reg [1:0] scan_req_state_q;
  reg [CHAN_W-1:0] scan_chan_q;
  reg scan_pend_q;
  reg [15:0] beacon_start_offset_q;
  reg [7:0] link_quality_q;
  reg [7:0] signal_strength_q;
  reg ack_q;

  // ---------------------------------------------------------------------------
  // decoded requests and procedure events
  // ---------------------------------------------------------------------------
  // a write lands on the edge that completes the transfer
  wire wr = avs_write & ack_q;
  wire rd = avs_read & ~ack_q;
  wire [31:0] wd = avs_writedata;
  wire cmd_wr = wr && avs_address == `PMM_OFS_CMD;
  wire st_wr = wr && avs_address == `PMM_OFS_STATUS;
  wire mib_wr = wr && avs_address == `PMM_OFS_MIB;
  wire rt_en_cmd = cmd_wr && wd[`PMM_CMD_RT_EN];
  wire rt_dis_cmd = cmd_wr && wd[`PMM_CMD_RT_DIS] && !wd[`PMM_CMD_RT_EN];
  wire scan_cmd = cmd_wr && wd[`PMM_CMD_SCAN] && !scan_pend_q;
  wire mac_rst_cmd = cmd_wr && wd[`PMM_CMD_MAC_RST];
  wire seq_idle = state_q == ST_IDLE;
  wire phy_busy = state_q == ST_PHY;
  wire mac_busy = state_q == ST_MAC;
  wire seq_last = cnt_q == 4'h1;
  wire phy_done = phy_busy && seq_last;
  wire mac_done = mac_busy && seq_last;
  wire scan_apply = scan_pend_q && seq_idle;
  wire hdr_ok = hdr_rx && scan_state_q != `PMM_SCAN_DISABLED;
  reg [31:0] rdata_d;
  reg [`PMM_ST_W-1:0] st_set;
  reg [`PMM_ST_W-1:0] st_val;

  // ---------------------------------------------------------------------------
  // read data select
  // ---------------------------------------------------------------------------
  always @* begin
    case (avs_address)
      `PMM_OFS_STATUS: rdata_d = {{(32-`PMM_ST_W){1'b0}}, status_q};
      `PMM_OFS_MIB: rdata_d = {29'h0, security_mode_sel_q, device_addr_kind_q};
      `PMM_OFS_SCAN: rdata_d = {{(32-CHAN_W-2){1'b0}}, scan_chan_q, scan_state_q};
      `PMM_OFS_TIMER: rdata_d = range_timer_value_q;
      `PMM_OFS_REPORT: rdata_d = {16'h0000, beacon_start_offset_q};
      `PMM_OFS_REPORT2: rdata_d = {16'h0000, signal_strength_q, link_quality_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------------------
  // bus slave: one wait cycle, answer on the second edge
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
      if (rd) begin
        avs_readdata <= rdata_d;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // confirm flag set events and values
  // ---------------------------------------------------------------------------
  always @* begin
    st_set = {`PMM_ST_W{1'b0}};
    st_val = {`PMM_ST_W{1'b0}};
    st_set[`PMM_ST_PHY_CONF] = phy_done;
    st_val[`PMM_ST_PHY_CONF] = 1'b1;
    st_set[`PMM_ST_PHY_OUT] = phy_done;
    st_val[`PMM_ST_PHY_OUT] = `PMM_OUT_SUCCESS;
    st_set[`PMM_ST_RT_EN_CONF] = rt_en_cmd;
    st_val[`PMM_ST_RT_EN_CONF] = 1'b1;
    st_set[`PMM_ST_RT_DIS_CONF] = rt_dis_cmd;
    st_val[`PMM_ST_RT_DIS_CONF] = 1'b1;
    st_set[`PMM_ST_MAC_CONF] = mac_done;
    st_val[`PMM_ST_MAC_CONF] = 1'b1;
    st_set[`PMM_ST_MAC_OUT] = mac_done;
    st_val[`PMM_ST_MAC_OUT] = `PMM_OUT_SUCCESS;
    st_set[`PMM_ST_SCAN_CONF] = scan_apply;
    st_val[`PMM_ST_SCAN_CONF] = 1'b1;
    st_set[`PMM_ST_SCAN_OUT] = scan_apply;
    st_val[`PMM_ST_SCAN_OUT] = `PMM_OUT_SUCCESS;
    st_set[`PMM_ST_HDR] = hdr_ok;
    st_val[`PMM_ST_HDR] = 1'b1;
    // live copy of the timer enable
    st_set[`PMM_ST_RT_ON] = 1'b1;
    st_val[`PMM_ST_RT_ON] = range_timer_on_q;
  end

  // ---------------------------------------------------------------------------
  // sticky flags: write one clears, hardware set wins
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `PMM_ST_W; gi = gi + 1) begin : g_flag
      reg flag_q;
      always @(posedge clk) begin
        if (srst) begin
          flag_q <= 1'b0;
        end else if (st_set[gi]) begin
          flag_q <= st_val[gi];
        end else if (st_wr && wd[gi]) begin
          flag_q <= 1'b0;
        end
      end
      assign status_q[gi] = flag_q;
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // ranging timer enable and capture
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      range_timer_on_q <= 1'b0;
      range_timer_value_q <= 32'h0000_0000;
    end else if (phy_busy) begin
      range_timer_on_q <= 1'b0;
      range_timer_value_q <= 32'h0000_0000;
    end else begin
      if (rt_en_cmd) begin
        range_timer_on_q <= 1'b1;
      end else if (rt_dis_cmd) begin
        range_timer_on_q <= 1'b0;
      end
      if (range_timer_on_q) begin
        range_timer_value_q <= range_timer_count;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // attribute store
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      device_addr_kind_q <= `PMM_ADDR_PRIVATE;
      security_mode_sel_q <= 2'h0;
    end else if (mac_busy) begin
      device_addr_kind_q <= `PMM_ADDR_PRIVATE;
      security_mode_sel_q <= 2'h0;
    end else if (mib_wr) begin
      device_addr_kind_q <= wd[0];
      // out-of-range security modes leave the old value
      if (wd[2:1] <= `PMM_SEC_MAX) begin
        security_mode_sel_q <= wd[2:1];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // scan request, apply and channel
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      scan_state_q <= `PMM_SCAN_DISABLED;
      scan_req_state_q <= `PMM_SCAN_DISABLED;
      scan_chan_q <= {CHAN_W{1'b0}};
      scan_pend_q <= 1'b0;
      channel_sel <= {CHAN_W{1'b0}};
    end else begin
      if (scan_cmd) begin
        scan_req_state_q <= wd[9:8];
        scan_chan_q <= wd[CHAN_W+15:16];
        scan_pend_q <= 1'b1;
      end
      // held back while a reset procedure runs
      if (scan_apply) begin
        scan_state_q <= scan_req_state_q;
        channel_sel <= scan_chan_q;
        scan_pend_q <= 1'b0;
      end
      if (mac_busy) begin
        scan_state_q <= `PMM_SCAN_DISABLED;
        scan_pend_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // scan gating by mode
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      scan_active <= 1'b0;
    end else begin
      case (scan_state_q)
        `PMM_SCAN_ONLY: scan_active <= 1'b1;
        `PMM_SCAN_EXCEPT_BP: scan_active <= ~beacon_period;
        `PMM_SCAN_WHEN_IDLE: scan_active <= ~link_scheduled;
        default: scan_active <= 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // mac traffic permission
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      mac_txrx_enable <= 1'b0;
    end else if (mac_busy || mac_rst_cmd) begin
      mac_txrx_enable <= 1'b0;
    end else if (scan_state_q == `PMM_SCAN_ONLY) begin
      mac_txrx_enable <= 1'b0;
    end else if (wr && !st_wr && seq_idle) begin
      mac_txrx_enable <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // header report capture
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      beacon_start_offset_q <= 16'h0000;
      link_quality_q <= 8'h00;
      signal_strength_q <= 8'h00;
    end else if (hdr_ok) begin
      beacon_start_offset_q <= hdr_beacon_start_offset;
      link_quality_q <= hdr_link_quality;
      signal_strength_q <= hdr_signal_strength;
    end
  end

  // ---------------------------------------------------------------------------
  // reset procedure sequencer
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      phy_tx_clear <= 1'b0;
      phy_rx_clear <= 1'b0;
      phy_sense_clear <= 1'b0;
      mac_buf_flush <= 1'b0;
    end else begin
      phy_tx_clear <= 1'b0;
      phy_rx_clear <= 1'b0;
      phy_sense_clear <= 1'b0;
      mac_buf_flush <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          cnt_q <= CNT_LOAD;
          if (cmd_wr && wd[`PMM_CMD_PHY_RST]) begin
            state_q <= ST_PHY;
          end else if (mac_rst_cmd) begin
            state_q <= ST_MAC;
          end
        end
        ST_PHY: begin
          phy_tx_clear <= 1'b1;
          phy_rx_clear <= 1'b1;
          phy_sense_clear <= 1'b1;
          cnt_q <= cnt_q - 4'h1;
          if (seq_last) begin
            state_q <= ST_IDLE;
          end
        end
        ST_MAC: begin
          mac_buf_flush <= 1'b1;
          cnt_q <= cnt_q - 4'h1;
          if (seq_last) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
